// *** verilog/clk_gate_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef CLK_GATE_REGS_SVH
`define CLK_GATE_REGS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_SW_FREQ 8'h04
`define REG_WD_LOAD 8'h08
`define REG_WD_KICK 8'h0C
`define REG_STATUS 8'h10
`define REG_CMD 8'h14

// control fields
`define CTRL_WD_EN 0
`define CTRL_WD_TO_SW 1
`define CTRL_RST_ON_WD 2
`define CTRL_RST_ON_FREQ 3
`define CTRL_SW_EN 4
`define CTRL_RST 5'h00

// status fields
`define ST_FREQ_LSB 0
`define ST_STRAP_LSB 5
`define ST_LOW_RATE 10
`define ST_WD_EXP 11
`define ST_CMD_ERR 12
`define ST_STRAP_DONE 13

// command code fields
`define CMD_SINGLE 7
`define CMD_OFFS_MSB 6

// reset values
`define WD_LOAD_RST 16'hFFFF
`define SW_FREQ_RST 5'h00

// timing
`define CLK_PERIOD_NS 50
`define STRAP_WAIT_NS 500
`define STRAP_WAIT_CYC ((`STRAP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_NS 1000
`define RST_PULSE_CYC ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// output half periods in hclk cycles
`define REF_HALF 4'h3
`define PERIPH_HALF 4'h2
`define FIXED48_HALF 4'h1
`define LOW24_HALF 4'h2
`define PROC_HALF_BASE 4'h1
`define GFX_HALF_BASE 4'h2

`endif

// *** verilog/clk_gate_pkg.sv ***
// types shared by the clock output gating control
package clk_gate_pkg;
   typedef enum logic [1:0] {
      RS_IDLE = 2'b01,
      RS_HOLD = 2'b10
   } rst_state_e;
   typedef logic [4:0] freq_sel_t;
endpackage

// *** verilog/strap_capture.sv ***
// strap sampling after reset release
`timescale 1ns/1ps
module strap_capture #(
   parameter int W = 6,
   parameter int WAIT = 10
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // strap pins
   input wire logic [W-1:0] pin_i,
   // captured values
   output logic [W-1:0] value_q,
   output logic done_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [W-1:0] value_d;
   logic done_d;

   // ****************************************
   // capture once, then hold until reset
   // ****************************************
   always_comb begin
      cnt_d = cnt_q;
      value_d = value_q;
      done_d = done_q;
      if (!done_q) begin
         if (cnt_q == 16'(WAIT)) begin
            value_d = s2_q; // R12
            done_d = 1'b1; // R12
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         cnt_q <= 16'h0000;
         value_q <= '0;
         done_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         cnt_q <= cnt_d;
         value_q <= value_d;
         done_q <= done_d;
      end
   end
endmodule

// *** verilog/clk_group_gate.sv ***
// one gated output clock group with whole-cycle stop and restart
`timescale 1ns/1ps
module clk_group_gate #(
   parameter int COPIES = 1,
   parameter int HW = 4
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic halt_n_i,
   input wire logic [HW-1:0] half_i,
   // outputs
   output logic [COPIES-1:0] clk_q,
   output logic [COPIES-1:0] clk_n_q
);
   logic s1_q;
   logic s2_q;
   logic run_q;
   logic run_d;
   logic ph_q;
   logic ph_d;
   logic [HW-1:0] cnt_q;
   logic [HW-1:0] cnt_d;

   // ****************************************
   // divider; run changes only at a falling edge or while idle low
   // ****************************************
   always_comb begin
      run_d = run_q;
      ph_d = ph_q;
      cnt_d = cnt_q;
      if (!run_q) begin
         ph_d = 1'b0;
         cnt_d = '0;
         run_d = s2_q; // R13
      end else if (cnt_q >= half_i - HW'(1)) begin
         cnt_d = '0;
         ph_d = ~ph_q;
         if (ph_q) begin
            run_d = s2_q; // R13
         end
      end else begin
         cnt_d = cnt_q + HW'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         run_q <= 1'b0;
         ph_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         s1_q <= halt_n_i;
         s2_q <= s1_q;
         run_q <= run_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
      end
   end

   // ****************************************
   // output copies
   // ****************************************
   for (genvar i = 0; i < COPIES; i++) begin : g_copy
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            clk_q[i] <= 1'b0;
            clk_n_q[i] <= 1'b1;
         end else begin
            clk_q[i] <= ph_d;
            clk_n_q[i] <= ~ph_d;
         end
      end
   end
endmodule

// *** verilog/clock_output_gating_control.sv ***
// clock output gating, strap capture, watchdog and system reset control
//
// Notes on behaviour
// R1 - reference halt stops three reference, fixed 48 and selectable low outputs
// R2 - peripheral halt stops gated peripheral outputs zero to eight and early output
// R3 - graphics halt stops all three graphics port outputs
// R4 - processor halt stops the chipset processor clock pair
// R5 - free-running peripheral output is never gated by peripheral halt
// R6 - five strap pins pick processor and graphics frequency
// R7 - rate strap on gated peripheral pin zero picks 24 or 48 MHz
// R8 - system reset is open drain, only pulled low or released
// R9 - system reset may follow watchdog expiry or a software frequency change
// R10 - watchdog expiry moves outputs to strap or software frequency
// R11 - command bit 7 low is block access with offset zero; high is indexed
// R12 - straps sampled once after reset, held until next reset
// R13 - halt inputs synchronised; outputs stop and restart on whole cycles
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "clk_gate_regs.svh"
module clock_output_gating_control
   import clk_gate_pkg::*;
#(
   parameter int WD_W = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // halt inputs, active low
   input wire logic ref_clk_halt_n,
   input wire logic periph_clk_halt_n,
   input wire logic gfx_clk_halt_n,
   input wire logic proc_clk_halt_n,
   // strap-shared pins: 0 ref0, 1 ref1, 2 fixed48, 3 low, 4 free, 5 gated0
   input wire logic [5:0] strap_pin_i,
   output logic strap_pin_oe_n,
   // clock outputs
   output logic [2:0] ref_clk_out,
   output logic fixed_48_clk,
   output logic selectable_low_clk,
   output logic [8:0] periph_clk_gated,
   output logic periph_clk_early,
   output logic periph_clk_free,
   output logic [2:0] gfx_port_clk,
   output logic proc_clk_chipset_true,
   output logic proc_clk_chipset_comp,
   // open-drain system reset
   output logic sys_rst_n_o,
   output logic sys_rst_n_oe_n
);
   // ****************************************
   // declarations
   // ****************************************
   logic [5:0] strap_val;
   logic strap_done;
   freq_sel_t freq_strap_sel;
   logic low_speed_rate_strap;
   logic strap_oe_n_q;
   logic strap_oe_n_d;

   logic wr_pend_q;
   logic wr_pend_d;
   logic [7:0] wr_addr_q;
   logic [7:0] wr_addr_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic addr_ok;
   logic wr_ctrl;
   logic wr_freq;
   logic wr_load;
   logic wr_kick;
   logic wr_stat;
   logic wr_cmd;

   logic [4:0] ctrl_q;
   logic [4:0] ctrl_d;
   freq_sel_t sw_freq_q;
   freq_sel_t sw_freq_d;
   freq_sel_t act_freq_q;
   freq_sel_t act_freq_d;
   logic [WD_W-1:0] wd_load_q;
   logic [WD_W-1:0] wd_load_d;
   logic [WD_W-1:0] wd_cnt_q;
   logic [WD_W-1:0] wd_cnt_d;
   logic wd_exp_q;
   logic wd_exp_d;
   logic wd_fire;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic cmd_err_q;
   logic cmd_err_d;
   logic cmd_bad;
   logic freq_chg;
   logic boot_q;
   logic boot_d;

   rst_state_e rs_q;
   rst_state_e rs_d;
   logic [15:0] rcnt_q;
   logic [15:0] rcnt_d;
   logic rst_req;
   logic rst_oe_n_q;
   logic rst_oe_n_d;

   logic [3:0] proc_half;
   logic [3:0] gfx_half;
   logic [3:0] low_half;
   logic [2:0] ref_ph;
   logic ref_hold;
   logic [1:0] low_ph;

   // ****************************************
   // strap capture
   // ****************************************
   strap_capture #(
      .W(6),
      .WAIT(`STRAP_WAIT_CYC)
   ) u_strap (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_i(strap_pin_i),
      .value_q(strap_val),
      .done_q(strap_done)
   );

   assign freq_strap_sel = strap_val[4:0]; // R6
   assign low_speed_rate_strap = strap_val[5]; // R7

   // pins released for straps, then driven as clocks
   always_comb begin
      strap_oe_n_d = ~strap_done; // R12
   end

   // ****************************************
   // ahb-lite decode
   // ****************************************
   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_ctrl = wr_pend_q && (wr_addr_q == `REG_CTRL);
   assign wr_freq = wr_pend_q && (wr_addr_q == `REG_SW_FREQ);
   assign wr_load = wr_pend_q && (wr_addr_q == `REG_WD_LOAD);
   assign wr_kick = wr_pend_q && (wr_addr_q == `REG_WD_KICK);
   assign wr_stat = wr_pend_q && (wr_addr_q == `REG_STATUS);
   assign wr_cmd = wr_pend_q && (wr_addr_q == `REG_CMD);

   always_comb begin
      wr_pend_d = addr_ok && hwrite;
      wr_addr_d = haddr[7:0];
      hrdata_d = hrdata_q;
      if (addr_ok && !hwrite) begin
         hrdata_d = 32'h0000_0000;
         unique case (haddr[7:0])
            `REG_CTRL: hrdata_d[4:0] = ctrl_q;
            `REG_SW_FREQ: hrdata_d[4:0] = sw_freq_q;
            `REG_WD_LOAD: hrdata_d[WD_W-1:0] = wd_load_q;
            `REG_WD_KICK: hrdata_d[WD_W-1:0] = wd_cnt_q;
            `REG_STATUS: begin
               hrdata_d[`ST_FREQ_LSB +: 5] = act_freq_q;
               hrdata_d[`ST_STRAP_LSB +: 5] = freq_strap_sel;
               hrdata_d[`ST_LOW_RATE] = low_speed_rate_strap;
               hrdata_d[`ST_WD_EXP] = wd_exp_q;
               hrdata_d[`ST_CMD_ERR] = cmd_err_q;
               hrdata_d[`ST_STRAP_DONE] = strap_done;
            end
            `REG_CMD: hrdata_d[7:0] = cmd_q;
            default: hrdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // control, command code and frequency selection
   // ****************************************
   assign cmd_bad = !hwdata[`CMD_SINGLE] && (hwdata[`CMD_OFFS_MSB:0] != 7'h00);
   assign wd_fire = ctrl_q[`CTRL_WD_EN] && (wd_cnt_q == '0);

   always_comb begin
      ctrl_d = ctrl_q;
      sw_freq_d = sw_freq_q;
      act_freq_d = act_freq_q;
      wd_load_d = wd_load_q;
      cmd_d = cmd_q;
      cmd_err_d = cmd_err_q;
      boot_d = boot_q;
      freq_chg = 1'b0;
      if (wr_ctrl) begin
         ctrl_d = hwdata[4:0];
      end
      if (wr_load) begin
         wd_load_d = hwdata[WD_W-1:0];
      end
      if (wr_cmd) begin
         cmd_d = hwdata[7:0]; // R11
      end
      if (wr_stat && hwdata[`ST_CMD_ERR]) begin
         cmd_err_d = 1'b0;
      end
      if (wr_cmd && cmd_bad) begin
         cmd_err_d = 1'b1; // R11
      end
      if (wr_freq) begin
         sw_freq_d = hwdata[4:0];
      end
      if (strap_done && !boot_q) begin
         act_freq_d = freq_strap_sel; // R6
         boot_d = 1'b1;
      end else if (wd_fire) begin
         act_freq_d = ctrl_q[`CTRL_WD_TO_SW] ? sw_freq_q : freq_strap_sel; // R10
      end else if (wr_freq && ctrl_q[`CTRL_SW_EN]) begin
         act_freq_d = hwdata[4:0];
         freq_chg = (hwdata[4:0] != act_freq_q);
      end
   end

   // ****************************************
   // watchdog
   // ****************************************
   always_comb begin
      wd_cnt_d = wd_cnt_q;
      wd_exp_d = wd_exp_q;
      if (wr_stat && hwdata[`ST_WD_EXP]) begin
         wd_exp_d = 1'b0;
      end
      if (!ctrl_q[`CTRL_WD_EN] || wr_kick || wr_ctrl) begin
         wd_cnt_d = wr_load ? hwdata[WD_W-1:0] : wd_load_q;
      end else if (wd_fire) begin
         wd_cnt_d = wd_load_q;
         wd_exp_d = 1'b1; // R10
      end else begin
         wd_cnt_d = wd_cnt_q - WD_W'(1);
      end
   end

   // ****************************************
   // system reset pulse
   // ****************************************
   assign rst_req = (wd_fire && ctrl_q[`CTRL_RST_ON_WD])
      || (freq_chg && ctrl_q[`CTRL_RST_ON_FREQ]); // R9

   always_comb begin
      rs_d = rs_q;
      rcnt_d = rcnt_q;
      unique case (rs_q)
         RS_IDLE: begin
            if (rst_req) begin
               rs_d = RS_HOLD;
               rcnt_d = 16'h0000;
            end
         end
         RS_HOLD: begin
            if (rcnt_q == 16'(`RST_PULSE_CYC - 1)) begin
               rs_d = RS_IDLE;
            end else begin
               rcnt_d = rcnt_q + 16'h0001;
            end
         end
         default: begin
            rs_d = RS_IDLE;
            rcnt_d = 16'h0000;
         end
      endcase
      rst_oe_n_d = (rs_d != RS_HOLD); // R8
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         ctrl_q <= `CTRL_RST;
         sw_freq_q <= `SW_FREQ_RST;
         act_freq_q <= `SW_FREQ_RST;
         wd_load_q <= WD_W'(`WD_LOAD_RST);
         wd_cnt_q <= WD_W'(`WD_LOAD_RST);
         wd_exp_q <= 1'b0;
         cmd_q <= 8'h00;
         cmd_err_q <= 1'b0;
         boot_q <= 1'b0;
         rs_q <= RS_IDLE;
         rcnt_q <= 16'h0000;
         rst_oe_n_q <= 1'b1;
         strap_oe_n_q <= 1'b1;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         hrdata_q <= hrdata_d;
         ctrl_q <= ctrl_d;
         sw_freq_q <= sw_freq_d;
         act_freq_q <= act_freq_d;
         wd_load_q <= wd_load_d;
         wd_cnt_q <= wd_cnt_d;
         wd_exp_q <= wd_exp_d;
         cmd_q <= cmd_d;
         cmd_err_q <= cmd_err_d;
         boot_q <= boot_d;
         rs_q <= rs_d;
         rcnt_q <= rcnt_d;
         rst_oe_n_q <= rst_oe_n_d;
         strap_oe_n_q <= strap_oe_n_d;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign sys_rst_n_o = 1'b0; // R8
   assign sys_rst_n_oe_n = rst_oe_n_q;
   assign strap_pin_oe_n = strap_oe_n_q;

   // ****************************************
   // output clock groups
   // ****************************************
   assign proc_half = `PROC_HALF_BASE + {2'b00, act_freq_q[1:0]}; // R6
   assign gfx_half = `GFX_HALF_BASE + {1'b0, act_freq_q[4:2]}; // R6
   assign low_half = low_speed_rate_strap ? `LOW24_HALF : `FIXED48_HALF; // R7

   clk_group_gate #(.COPIES(3), .HW(4)) u_ref (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(ref_clk_halt_n), // R1
      .half_i(`REF_HALF),
      .clk_q(ref_clk_out),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(1), .HW(4)) u_fixed48 (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(ref_clk_halt_n), // R1
      .half_i(`FIXED48_HALF),
      .clk_q(fixed_48_clk),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(1), .HW(4)) u_low (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(ref_clk_halt_n), // R1
      .half_i(low_half),
      .clk_q(selectable_low_clk),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(10), .HW(4)) u_periph (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(periph_clk_halt_n), // R2
      .half_i(`PERIPH_HALF),
      .clk_q({periph_clk_early, periph_clk_gated}),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(1), .HW(4)) u_free (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(1'b1), // R5
      .half_i(`PERIPH_HALF),
      .clk_q(periph_clk_free),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(3), .HW(4)) u_gfx (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(gfx_clk_halt_n), // R3
      .half_i(gfx_half),
      .clk_q(gfx_port_clk),
      .clk_n_q()
   );

   clk_group_gate #(.COPIES(1), .HW(4)) u_proc (
      .hclk(hclk),
      .hresetn(hresetn),
      .halt_n_i(proc_clk_halt_n), // R4
      .half_i(proc_half),
      .clk_q(proc_clk_chipset_true),
      .clk_n_q(proc_clk_chipset_comp)
   );
endmodule

// *** tb/power_mgmt_model.sv ***
// far side model: halt lines, strap resistors, reset pull-up
`timescale 1ns/1ps
module power_mgmt_model (
   // clock
   input wire logic hclk,
   // bench requests
   input wire logic [3:0] halt_req,
   input wire logic [5:0] strap_val,
   // design pins
   input wire logic strap_pin_oe_n,
   input wire logic [5:0] pin_drv,
   input wire logic sys_rst_n_o,
   input wire logic sys_rst_n_oe_n,
   // resolved lines
   output logic [3:0] halt_n,
   output logic [5:0] strap_pin_i,
   output logic sys_rst_wire
);
   // ****
   // halt lines change after a rising edge
   // ****
   initial halt_n = 4'hF;
   always @(posedge hclk) begin
      halt_n <= ~halt_req;
   end
   // straps held by resistors while pins are released
   assign strap_pin_i = strap_pin_oe_n ? strap_val : pin_drv;
   // pull-up wins while reset line is released
   assign sys_rst_wire = sys_rst_n_oe_n ? 1'b1 : sys_rst_n_o;
endmodule

// *** tb/clock_gating_properties.sv ***
// port checks for the clock output gating control
`timescale 1ns/1ps
module clock_gating_properties (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // halt inputs
   input wire logic ref_clk_halt_n,
   input wire logic periph_clk_halt_n,
   input wire logic gfx_clk_halt_n,
   input wire logic proc_clk_halt_n,
   // outputs
   input wire logic strap_pin_oe_n,
   input wire logic [2:0] ref_clk_out,
   input wire logic fixed_48_clk,
   input wire logic selectable_low_clk,
   input wire logic [8:0] periph_clk_gated,
   input wire logic periph_clk_early,
   input wire logic periph_clk_free,
   input wire logic [2:0] gfx_port_clk,
   input wire logic proc_clk_chipset_true,
   input wire logic proc_clk_chipset_comp,
   input wire logic sys_rst_n_o,
   input wire logic sys_rst_n_oe_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****
   // reset pulse length counter
   // ****
   logic [7:0] low_cnt_q;
   logic [7:0] low_cnt_d;
   always_comb begin
      low_cnt_d = sys_rst_n_oe_n ? 8'h00 : low_cnt_q + 8'h01;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_q <= 8'h00;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end
   // ****
   // halt held long enough for a stop
   // ****
   // sync plus up to one whole output period before the group stops
   sequence ref_held; !ref_clk_halt_n [*8] ##1 !ref_clk_halt_n; endsequence
   sequence per_held; !periph_clk_halt_n [*8]; endsequence
   sequence gfx_held;
      !gfx_clk_halt_n [*8] ##1 !gfx_clk_halt_n [*8] ##1 !gfx_clk_halt_n [*5];
   endsequence
   sequence proc_held; !proc_clk_halt_n [*8] ##1 !proc_clk_halt_n [*3]; endsequence
   a_ref_group_stop: assert property (ref_held |->
      ref_clk_out == 3'h0 && !fixed_48_clk && !selectable_low_clk) else $error("ref group runs");
   a_periph_group_stop: assert property (per_held |->
      periph_clk_gated == 9'h000 && !periph_clk_early) else $error("periph group runs");
   a_gfx_group_stop: assert property (gfx_held |->
      gfx_port_clk == 3'h0) else $error("gfx group runs");
   a_proc_pair_stop: assert property (proc_held |->
      !proc_clk_chipset_true && proc_clk_chipset_comp) else $error("proc pair runs");
   a_free_clk_runs: assert property ($rose(periph_clk_free) |->
      ##4 $rose(periph_clk_free)) else $error("free clock period wrong");
   a_rst_never_high: assert property (sys_rst_n_o == 1'b0)
      else $error("reset line driven high");
   a_rst_pulse_len: assert property ($rose(sys_rst_n_oe_n) |-> low_cnt_q == 8'h14)
      else $error("reset pulse length wrong");
   a_strap_pins_kept: assert property (!strap_pin_oe_n |=> !strap_pin_oe_n)
      else $error("strap pins released again");
endmodule
bind clock_output_gating_control clock_gating_properties chk (.hclk, .hresetn,
   .ref_clk_halt_n, .periph_clk_halt_n, .gfx_clk_halt_n, .proc_clk_halt_n,
   .strap_pin_oe_n, .ref_clk_out, .fixed_48_clk, .selectable_low_clk, .periph_clk_gated,
   .periph_clk_early, .periph_clk_free, .gfx_port_clk, .proc_clk_chipset_true,
   .proc_clk_chipset_comp, .sys_rst_n_o, .sys_rst_n_oe_n);

// *** tb/clock_output_gating_control_bench.sv ***
// self-checking bench for the clock output gating control
`timescale 1ns/1ps
`include "clk_gate_regs.svh"
module clock_output_gating_control_bench;
   // ****
   // signals
   // ****
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, oe_n, rst_o, rst_oe_n;
   logic rst_wire, saw_rst, f48, low, pe, pf, pt, pc;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, ref_clk, gfx_clk;
   logic [3:0] halt_req, halt_n;
   logic [5:0] strap_val, strap_i;
   logic [8:0] pg;
   int error_cnt, checks;
   localparam logic [7:0] CODES [4] = '{8'h05, 8'h85, 8'h00, 8'h80};
   clock_output_gating_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ref_clk_halt_n(halt_n[0]), .periph_clk_halt_n(halt_n[1]),
      .gfx_clk_halt_n(halt_n[2]), .proc_clk_halt_n(halt_n[3]), .strap_pin_i(strap_i),
      .strap_pin_oe_n(oe_n), .ref_clk_out(ref_clk), .fixed_48_clk(f48),
      .selectable_low_clk(low), .periph_clk_gated(pg), .periph_clk_early(pe),
      .periph_clk_free(pf), .gfx_port_clk(gfx_clk), .proc_clk_chipset_true(pt),
      .proc_clk_chipset_comp(pc), .sys_rst_n_o(rst_o), .sys_rst_n_oe_n(rst_oe_n));
   power_mgmt_model pm (.hclk(hclk), .halt_req(halt_req), .strap_val(strap_val),
      .strap_pin_oe_n(oe_n), .pin_drv({pg[0], pf, low, f48, ref_clk[1:0]}),
      .sys_rst_n_o(rst_o), .sys_rst_n_oe_n(rst_oe_n), .halt_n(halt_n),
      .strap_pin_i(strap_i), .sys_rst_wire(rst_wire));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (rst_wire === 1'b0) saw_rst <= 1'b1;
   end
   // ****
   // helpers
   // ****
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %0h expected %0h", $time, s, e);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task hang;
      error_cnt++;
      results;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge hclk);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 99);
      rd = hrdata;
      if (n >= 99) hang;
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, `REG_STATUS, 32'h0);
         n++;
      end while (rd[b] !== 1'b1 && n < 60);
      if (n >= 60) hang;
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return pt;
         1: return gfx_clk[0];
         default: return low;
      endcase
   endfunction
   function automatic logic grp(input int g);
      case (g)
         0: return |{ref_clk, f48, low};
         1: return |{pg, pe};
         2: return |gfx_clk;
         default: return pt | ~pc;
      endcase
   endfunction
   task automatic half_of(input int s, output int h);
      int n;
      n = 0;
      h = 0;
      while (sig(s) !== 1'b0 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      while (sig(s) !== 1'b1 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      while (sig(s) === 1'b1 && n < 200) begin
         @(posedge hclk);
         n++;
         h++;
      end
      if (n >= 200) hang;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_straps;
      int h;
      poll(`ST_STRAP_DONE);
      chk(rd[9:5], 5'h15);
      chk(rd[10], 1'b1);
      chk(rd[4:0], 5'h15);
      chk(oe_n, 1'b0);
      strap_val <= 6'h0A;
      bus(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h0);
      chk(hresp, 1'b0);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd[10:5], 6'h35);
      half_of(0, h);
      chk(h, 2);
      half_of(1, h);
      chk(h, 7);
      half_of(2, h);
      chk(h, 2);
      $display("strap test done");
   endtask
   task automatic t_halt;
      logic acc;
      int hi;
      for (int g = 0; g < 4; g++) begin
         halt_req[g] <= 1'b1;
         repeat (40) @(posedge hclk);
         acc = 1'b0;
         hi = 0;
         repeat (12) begin
            @(posedge hclk);
            acc = acc | grp(g);
            hi += int'(pf === 1'b1);
         end
         chk(acc, 1'b0);
         chk(hi, 6);
         halt_req[g] <= 1'b0;
         acc = 1'b0;
         repeat (40) begin
            @(posedge hclk);
            acc = acc | grp(g);
         end
         chk(acc, 1'b1);
      end
      $display("halt test done");
   endtask
   task automatic t_wd;
      int h;
      bus(1'b1, `REG_WD_LOAD, 32'h14);
      bus(1'b1, `REG_SW_FREQ, 32'h6);
      saw_rst <= 1'b0;
      bus(1'b1, `REG_CTRL, 32'h7);
      poll(`ST_WD_EXP);
      chk(rd[4:0], 5'h06);
      bus(1'b1, `REG_CTRL, 32'h0);
      repeat (25) @(posedge hclk);
      chk(saw_rst, 1'b1);
      half_of(0, h);
      chk(h, 3);
      bus(1'b1, `REG_STATUS, 32'h800);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd[11], 1'b0);
      bus(1'b1, `REG_CTRL, 32'h1);
      repeat (10) bus(1'b1, `REG_WD_KICK, 32'h0);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd[11], 1'b0);
      poll(`ST_WD_EXP);
      chk(rd[4:0], 5'h15);
      bus(1'b1, `REG_CTRL, 32'h0);
      bus(1'b1, `REG_STATUS, 32'h800);
      bus(1'b0, `REG_WD_KICK, 32'h0);
      chk(rd, 32'h14);
      $display("watchdog test done");
   endtask
   task automatic t_sw;
      saw_rst <= 1'b0;
      bus(1'b1, `REG_CTRL, 32'h18);
      bus(1'b1, `REG_SW_FREQ, 32'h3);
      bus(1'b0, `REG_STATUS, 32'h0);
      chk(rd[4:0], 5'h03);
      repeat (25) @(posedge hclk);
      chk(saw_rst, 1'b1);
      saw_rst <= 1'b0;
      bus(1'b1, `REG_SW_FREQ, 32'h3);
      repeat (25) @(posedge hclk);
      chk(saw_rst, 1'b0);
      bus(1'b1, `REG_CTRL, 32'h0);
      $display("software frequency test done");
   endtask
   task automatic t_cmd;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, `REG_CMD, {24'h000000, CODES[i]});
         bus(1'b0, `REG_STATUS, 32'h0);
         chk(rd[12], i == 0);
         bus(1'b1, `REG_STATUS, 32'h1000);
      end
      $display("command code test done");
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      halt_req = 4'h0;
      strap_val = 6'h35;
      saw_rst = 1'b0;
      error_cnt = 0;
      checks = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_straps;
      t_halt;
      t_wd;
      t_sw;
      t_cmd;
      results;
   end
endmodule
